// File: logic/fce_pkg.sv
// package: constants and carriers for the fifo cascade expansion controller
package fce_pkg;
  localparam int unsigned NUM_DEV = 2;
  localparam int unsigned DEV_W = 18;
  localparam int unsigned BUS_W = NUM_DEV * DEV_W;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned MRS_NS = 200;
  localparam int unsigned MRS_CYC = (MRS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_CLOCK_PERIOD_CYC = 1;
  localparam int unsigned XFER_PERIOD_CYC = 1;
  localparam int unsigned SKEW_EXTRA_CYC = 2;
  localparam int unsigned RIPPLE_CYC =
      (NUM_DEV - 1) * 4 * XFER_PERIOD_CYC + 3 * READ_CLOCK_PERIOD_CYC + SKEW_EXTRA_CYC;
  localparam int unsigned BUBBLE_CYC =
      (NUM_DEV - 1) * 3 * XFER_PERIOD_CYC + 2 * READ_CLOCK_PERIOD_CYC + SKEW_EXTRA_CYC;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_WDATA_LO = 8'h08;
  localparam logic [7:0] OFS_WDATA_HI = 8'h0C;
  localparam logic [7:0] OFS_RDATA_LO = 8'h10;
  localparam logic [7:0] OFS_RDATA_HI = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  // ctrl fields
  localparam int unsigned CTRL_FALL_THROUGH = 0;
  localparam int unsigned CTRL_RESET_GO = 1;
  localparam int unsigned CTRL_WRITE_GO = 2;
  localparam int unsigned CTRL_READ_GO = 3;
  // irq fields
  localparam int unsigned IRQ_WDONE = 0;
  localparam int unsigned IRQ_RDONE = 1;
  localparam int unsigned IRQ_RESET_DONE = 2;
  localparam int unsigned IRQ_LATE = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

  typedef enum logic [4:0] {
    FCE_IDLE = 5'b00001,
    FCE_MRS = 5'b00010,
    FCE_WRITE = 5'b00100,
    FCE_READ = 5'b01000,
    FCE_READ_HOLD = 5'b10000
  } fce_state_e;

  // per-device pins facing one fifo
  typedef struct packed {
    logic [NUM_DEV-1:0] flag_a_n;
    logic [NUM_DEV-1:0] flag_b_n;
  } fce_flags_s;
endpackage : fce_pkg

// File: logic/fce_flag_combine.sv
// combinational merging of per-device flags into composite flags
`timescale 1ns/1ps
`default_nettype none
module fce_flag_combine
  import fce_pkg::*;
(
  input wire logic fall_through, // mode captured at master reset
  input wire fce_flags_s flags, // empty/full or output/input ready, per device
  output logic rd_avail_n, // composite: low when a word can be read
  output logic wr_avail_n // composite: low when a word can be written
);
  always_comb begin
    if (fall_through) begin
      rd_avail_n = |flags.flag_a_n; // see [R5]
      wr_avail_n = |flags.flag_b_n; // see [R5]
    end else begin
      // low-active empty/full: any device still empty or full keeps the merged flag high
      rd_avail_n = ~(&flags.flag_a_n); // see [R4]
      wr_avail_n = ~(&flags.flag_b_n); // see [R4]
    end
  end
endmodule : fce_flag_combine
`default_nettype wire

// File: logic/fce_host.sv
// host controller driving a width-expanded or depth-expanded fifo array
//
// Notes on behaviour
// [R1] device reads asynchronously only in standard mode, never fall-through
// [R2] shared control to all devices; composite ready/empty/full flags
// [R3] paralleled devices may differ by one cycle on flag changes
// [R4] standard mode: AND the low-active empty flags, AND the full flags
// [R5] fall-through mode: OR output-ready flags, OR input-ready flags
// [R6] two devices side by side concatenate into one wide data bus
// [R7] never tie device output controls together; combine through a gate
// [R8] all width-paralleled devices have the same depth
// [R9] depth expansion only in fall-through; series chain, depths add
// [R10] select fall-through at master reset on every chained device
// [R11] first word ripples through without reads; read clocks run freely
// [R12] device with a word at its output drives output-ready low
// [R13] last output-ready low within (N-1)*4 transfer plus 3 read periods
// [R14] ripple latency applies only to first word into empty chain
// [R15] freed locations bubble back; each device drives input-ready low
// [R16] first input-ready low within (N-1)*3 transfer plus 2 write periods
// [R17] transfer clock is the faster of the write and read clocks
// [R18] allow extra latency cycles when skew requirement is not met
// [R19] chain: upstream output-ready to downstream write enable, reverse for read
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fce_host
  import fce_pkg::*;
#(
  parameter int unsigned N_DEV = NUM_DEV,
  parameter int unsigned W_DEV = DEV_W
)(
  input wire logic clock, // 50 MHz clock, also free-running fifo clocks; see [R11] see [R17]
  input wire logic rst_n, // asynchronous active-low reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic irq, // level interrupt
  output logic master_reset_n, // shared master reset to all devices
  output logic fall_through_timing, // mode strap, held during master reset
  output logic write_en_n, // shared write enable
  output logic read_en_n, // shared read enable
  output logic output_en_n, // shared output enable
  output logic [N_DEV*W_DEV-1:0] input_data_bus, // concatenated device inputs
  input wire logic [N_DEV*W_DEV-1:0] output_data_bus, // concatenated device outputs
  input wire logic [N_DEV-1:0] empty_flag_n, // per device empty or output-ready
  input wire logic [N_DEV-1:0] full_flag_n // per device full or input-ready
);
  // ****************************************
  // registers and state
  // ****************************************
  fce_state_e state_q;
  logic [31:0] ctrl_q;
  logic [N_DEV*W_DEV-1:0] wdata_q;
  logic [N_DEV*W_DEV-1:0] rdata_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [15:0] cnt_q;
  logic [15:0] wait_q;
  logic mode_q;
  logic rd_avail_n;
  logic wr_avail_n;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic stat_rd;
  logic cap_q;
  logic cap;
  fce_flags_s flags;

  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign pready = 1'b1;
  assign stat_rd = rd_acc && paddr == OFS_IRQ_STAT;

  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_STAT, OFS_WDATA_LO, OFS_WDATA_HI, OFS_RDATA_LO, OFS_RDATA_HI,
      OFS_IRQ_STAT, OFS_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = acc & ~hit;

  // ****************************************
  // composite flags
  // ****************************************
  assign flags.flag_a_n = empty_flag_n;
  assign flags.flag_b_n = full_flag_n;

  // per-device flags are merged through a gate, never wired together
  fce_flag_combine u_comb ( // see [R7]
    .fall_through(mode_q),
    .flags(flags),
    .rd_avail_n(rd_avail_n),
    .wr_avail_n(wr_avail_n)
  );

  // ****************************************
  // apb register writes
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_acc && paddr == OFS_CTRL) begin
        ctrl_q <= pwdata;
      end else begin
        // go bits self-clear once the engine accepts them
        if (state_q == FCE_IDLE) begin
          ctrl_q[CTRL_RESET_GO] <= 1'b0;
          ctrl_q[CTRL_WRITE_GO] <= ctrl_q[CTRL_WRITE_GO] & ctrl_q[CTRL_RESET_GO];
          ctrl_q[CTRL_READ_GO] <= ctrl_q[CTRL_READ_GO] &
              (ctrl_q[CTRL_RESET_GO] | ctrl_q[CTRL_WRITE_GO]);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q <= '0;
    end else if (wr_acc && paddr == OFS_WDATA_LO) begin
      wdata_q[31:0] <= pwdata; // see [R6]
    end else if (wr_acc && paddr == OFS_WDATA_HI) begin
      wdata_q[N_DEV*W_DEV-1:32] <= pwdata[N_DEV*W_DEV-33:0]; // see [R6]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= MASK_RST;
    end else if (wr_acc && paddr == OFS_IRQ_MASK) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  // set wins over the read-to-clear; only bits already shown in prdata are cleared,
  // so an event landing in the setup cycle of the read is not lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (stat_rd ? irq_stat_q & ~prdata[IRQ_W-1:0] : irq_stat_q) | irq_set;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // apb read mux
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: prdata <= ctrl_q;
        OFS_STAT: prdata <= {23'h0, state_q, mode_q, ~wr_avail_n, ~rd_avail_n, irq};
        OFS_RDATA_LO: prdata <= rdata_q[31:0];
        OFS_RDATA_HI: prdata <= {{(64-N_DEV*W_DEV){1'b0}}, rdata_q[N_DEV*W_DEV-1:32]};
        OFS_IRQ_STAT: prdata <= {{(32-IRQ_W){1'b0}}, irq_stat_q};
        OFS_IRQ_MASK: prdata <= {{(32-IRQ_W){1'b0}}, irq_mask_q};
        default: prdata <= '0;
      endcase
    end
  end

  // ****************************************
  // device sequencing engine
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FCE_MRS;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        FCE_IDLE: begin
          cnt_q <= '0;
          if (ctrl_q[CTRL_RESET_GO]) begin
            state_q <= FCE_MRS;
          end else if (ctrl_q[CTRL_WRITE_GO]) begin
            state_q <= FCE_WRITE;
          end else if (ctrl_q[CTRL_READ_GO]) begin
            state_q <= FCE_READ;
          end
        end
        FCE_MRS: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= 16'(MRS_CYC)) begin
            state_q <= FCE_IDLE;
          end
        end
        // shared enables drive every device at once
        FCE_WRITE: begin
          if (!wr_avail_n) begin // see [R2]
            state_q <= FCE_IDLE;
          end
        end
        FCE_READ: begin
          if (!rd_avail_n) begin // see [R2]
            state_q <= FCE_READ_HOLD;
          end
        end
        FCE_READ_HOLD: state_q <= FCE_IDLE;
        default: state_q <= FCE_IDLE;
      endcase
    end
  end

  // strap and mode are taken from ctrl at each master reset; all devices share them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
    end else if (state_q == FCE_MRS) begin
      mode_q <= ctrl_q[CTRL_FALL_THROUGH]; // see [R9] see [R10]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_reset_n <= 1'b0;
      fall_through_timing <= 1'b0;
      write_en_n <= 1'b1;
      read_en_n <= 1'b1;
      output_en_n <= 1'b1;
      input_data_bus <= '0;
    end else begin
      master_reset_n <= state_q != FCE_MRS;
      fall_through_timing <= state_q == FCE_MRS ? ctrl_q[CTRL_FALL_THROUGH] : mode_q;
      // write only while every device shows room; the slowest device gates it
      write_en_n <= !(state_q == FCE_WRITE && !wr_avail_n); // see [R3] see [R19]
      read_en_n <= !(state_q == FCE_READ && !rd_avail_n); // see [R3] see [R19]
      // one shared strobe set only fills and drains alike when depths match
      output_en_n <= state_q == FCE_MRS; // see [R8]
      input_data_bus <= wdata_q; // see [R6]
    end
  end

  // fall-through shows the head word before the strobe; standard mode shows it
  // only after the strobe edge, so its capture waits one more cycle
  assign cap = state_q == FCE_READ_HOLD ? mode_q : cap_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
      cap_q <= 1'b0;
    end else begin
      cap_q <= state_q == FCE_READ_HOLD && !mode_q;
      if (cap) begin
        rdata_q <= output_data_bus; // see [R6]
      end
    end
  end

  // ****************************************
  // latency watchdog and events
  // ****************************************
  // counts waits for data or room; budget covers ripple and bubble with skew margin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= '0;
    end else if (state_q == FCE_WRITE || state_q == FCE_READ) begin
      if (wait_q != 16'hFFFF) begin
        wait_q <= wait_q + 16'h0001;
      end
    end else begin
      wait_q <= '0;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_WDONE] = state_q == FCE_WRITE && !wr_avail_n;
    irq_set[IRQ_RDONE] = cap;
    irq_set[IRQ_RESET_DONE] = state_q == FCE_MRS && cnt_q >= 16'(MRS_CYC);
    // late flag only; a slow chain is not an error, merely over budget
    irq_set[IRQ_LATE] = (state_q == FCE_READ && wait_q == 16'(RIPPLE_CYC)) || // see [R13]
        (state_q == FCE_WRITE && wait_q == 16'(BUBBLE_CYC)); // see [R16] see [R18]
  end
endmodule : fce_host
`default_nettype wire

// File: sim/fce_host_checker.sv
// concurrent checks on the pins of the fifo array controller
`timescale 1ns/1ps
`default_nettype none
module fce_host_checker
  import fce_pkg::*;
#(
  parameter int unsigned N_DEV = NUM_DEV
)(
  input wire logic clock, // system clock
  input wire logic rst_n, // async active-low reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [7:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic master_reset_n, // shared master reset
  input wire logic fall_through_timing, // mode strap
  input wire logic write_en_n, // shared write strobe
  input wire logic read_en_n, // shared read strobe
  input wire logic output_en_n, // shared output enable
  input wire logic [N_DEV-1:0] empty_flag_n, // per device empty or output-ready
  input wire logic [N_DEV-1:0] full_flag_n // per device full or input-ready
);
  // ****************
  // composite flags
  // ****************
  logic wr_ok;
  logic rd_ok;
  logic bad_addr;
  // a single device's flag is not enough: paralleled devices may differ by a cycle
  assign wr_ok = fall_through_timing ? ~|full_flag_n : &full_flag_n;
  assign rd_ok = fall_through_timing ? ~|empty_flag_n : &empty_flag_n;
  assign bad_addr = (paddr > 8'h1C) || (paddr[1:0] != 2'h0);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_mrs_low;
    !master_reset_n [*8];
  endsequence
  a_ready_zero_wait: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && bad_addr |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (psel && penable && !bad_addr |-> !pslverr)
    else $error("error on mapped access");
  a_write_once: assert property (!write_en_n |=> write_en_n)
    else $error("write strobe longer than one cycle");
  a_read_once: assert property (!read_en_n |=> read_en_n)
    else $error("read strobe longer than one cycle");
  a_write_needs_room: assert property (!write_en_n |-> $past(wr_ok))
    else $error("write without composite room");
  a_read_needs_data: assert property (!read_en_n |-> $past(rd_ok))
    else $error("read without composite data");
  a_mrs_quiet: assert property (!master_reset_n |->
    write_en_n && read_en_n && output_en_n) else $error("strobes active in master reset");
  a_mrs_span: assert property ($fell(master_reset_n) |-> s_mrs_low)
    else $error("master reset too short");
  a_mode_frozen: assert property (master_reset_n && $past(master_reset_n)
    |-> $stable(fall_through_timing)) else $error("mode changed outside reset");
endmodule : fce_host_checker
bind fce_host fce_host_checker #(.N_DEV(N_DEV)) chk_u(.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .master_reset_n(master_reset_n), .fall_through_timing(fall_through_timing),
  .write_en_n(write_en_n), .read_en_n(read_en_n), .output_en_n(output_en_n),
  .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));
`default_nettype wire

// File: sim/fce_fifo_model.sv
// behavioural pair of width-expanded fifo devices facing the controller
`timescale 1ns/1ps
`default_nettype none
module fce_fifo_model
  import fce_pkg::*;
#(
  parameter int DEPTH = 4
)(
  input wire logic clock, // write, read and transfer clock
  input wire logic master_reset_n, // shared master reset
  input wire logic fall_through_timing, // mode strap sampled in reset
  input wire logic write_en_n, // shared write strobe
  input wire logic read_en_n, // shared read strobe
  input wire logic output_en_n, // shared output enable
  input wire logic [BUS_W-1:0] input_data_bus, // concatenated data in
  input wire logic skew, // delays the second device's flags by a cycle
  output logic [BUS_W-1:0] output_data_bus, // concatenated data out
  output logic [NUM_DEV-1:0] empty_flag_n, // empty or output-ready
  output logic [NUM_DEV-1:0] full_flag_n // full or input-ready
);
  // ****************
  // one device per slice
  // ****************
  for (genvar g = 0; g < NUM_DEV; g++) begin : dev
    logic [DEV_W-1:0] mem [DEPTH];
    logic [DEV_W-1:0] q;
    int cnt;
    int rp;
    int wp;
    logic ft, rd_q, e_q, f_q, wr, rd, e_raw, f_raw;
    assign wr = !write_en_n && cnt < DEPTH;
    assign rd = !read_en_n && cnt > 0;
    // undelayed flags; the skewed copy must follow these, not itself
    assign e_raw = ft ? (cnt == 0) : (cnt != 0);
    assign f_raw = ft ? (cnt == DEPTH) : (cnt != DEPTH);
    always_ff @(posedge clock or negedge master_reset_n) begin
      if (!master_reset_n) begin
        ft <= fall_through_timing;
        cnt <= 0;
        rp <= 0;
        wp <= 0;
        rd_q <= 1'b0;
      end else begin
        if (wr) mem[wp] <= input_data_bus[g*DEV_W +: DEV_W];
        if (wr) wp <= (wp + 1) % DEPTH;
        if (rd) q <= mem[rp];
        if (rd) rp <= (rp + 1) % DEPTH;
        cnt <= cnt + int'(wr) - int'(rd);
        rd_q <= rd;
        e_q <= e_raw;
        f_q <= f_raw;
      end
    end
    // head word shows without a read in fall-through; released bus never holds old data
    assign output_data_bus[g*DEV_W +: DEV_W] = output_en_n ? ~q :
        ((ft && cnt > 0 && !rd_q) ? mem[rp] : q);
    assign empty_flag_n[g] = (skew && g == 1) ? e_q : e_raw;
    assign full_flag_n[g] = (skew && g == 1) ? f_q : f_raw;
  end
endmodule : fce_fifo_model
`default_nettype wire

// File: sim/testbench.sv
// self-checking testbench driving the controller over apb against the fifo model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module testbench
  import fce_pkg::*;
;
  logic clock, rst_n, psel, penable, pwrite, pready, perr, pslverr, irq, skew;
  logic mrst_n, ft, wen_n, ren_n, oen_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [BUS_W-1:0] din, dout;
  logic [NUM_DEV-1:0] ef_n, ff_n;
  logic [IRQ_W-1:0] acc;
  logic [35:0] w;
  int fails, comparisons, m, i;
  fce_host dut_u(.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .master_reset_n(mrst_n), .fall_through_timing(ft),
    .write_en_n(wen_n), .read_en_n(ren_n), .output_en_n(oen_n), .input_data_bus(din),
    .output_data_bus(dout), .empty_flag_n(ef_n), .full_flag_n(ff_n));
  fce_fifo_model #(.DEPTH(4)) fifo_u(.clock(clock), .master_reset_n(mrst_n),
    .fall_through_timing(ft), .write_en_n(wen_n), .read_en_n(ren_n), .output_en_n(oen_n),
    .input_data_bus(din), .skew(skew), .output_data_bus(dout), .empty_flag_n(ef_n),
    .full_flag_n(ff_n));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ****************
  // bus tasks
  // ****************
  task automatic apb(input logic wr_i, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr_i;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read-clear status: bits seen while polling are kept so none is lost
  task automatic wait_irq(input int b);
    for (int k = 0; k < 100 && !acc[b]; k++) begin
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      acc = acc | r[IRQ_W-1:0];
    end
    `CHK(acc[b], 1'b1)
    acc[b] = 1'b0;
  endtask : wait_irq
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // ****************
  // tests
  // ****************
  initial begin
    {psel, penable, pwrite, skew, rst_n} = '0;
    paddr = '0;
    pwdata = '0;
    acc = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (MRS_CYC + 2) @(posedge clock);
    apb(1'b0, OFS_CTRL, 32'h0); `CHK(r, CTRL_RST)
    apb(1'b0, OFS_IRQ_MASK, 32'h0); `CHK(r[IRQ_W-1:0], MASK_RST)
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    apb(1'b0, 8'h24, 32'h0); `CHK({perr, r}, {1'b1, 32'h0})
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    acc = '0;
    for (m = 0; m < 2; m++) begin
      skew <= m[0];
      apb(1'b1, OFS_CTRL, 32'h2 | 32'(m));
      wait_irq(IRQ_RESET_DONE);
      for (i = 0; i < 4; i++) begin
        w = {4'(i + 9), 32'hC0DE_0000 | 32'(i)};
        apb(1'b1, OFS_WDATA_LO, w[31:0]);
        apb(1'b1, OFS_WDATA_HI, {28'h0, w[35:32]});
        apb(1'b1, OFS_CTRL, 32'h4 | 32'(m));
        wait_irq(IRQ_WDONE);
      end
      apb(1'b0, OFS_STAT, 32'h0); `CHK(r[3:1], {m[0], 2'b01})
      for (i = 0; i < 4; i++) begin
        apb(1'b1, OFS_CTRL, 32'h8 | 32'(m));
        wait_irq(IRQ_RDONE);
        apb(1'b0, OFS_RDATA_LO, 32'h0); `CHK(r, 32'hC0DE_0000 | 32'(i))
        apb(1'b0, OFS_RDATA_HI, 32'h0); `CHK(r[3:0], 4'(i + 9))
      end
      apb(1'b0, OFS_STAT, 32'h0); `CHK(r[3:1], {m[0], 2'b10})
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h1 << IRQ_WDONE);
    apb(1'b1, OFS_CTRL, 32'h5);
    for (i = 0; i < 50 && irq !== 1'b1; i++) @(negedge clock);
    `CHK(irq, 1'b1)
    apb(1'b0, OFS_IRQ_STAT, 32'h0); `CHK(r[IRQ_WDONE], 1'b1)
    @(negedge clock); `CHK(irq, 1'b0)
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h9);
    repeat (BUBBLE_CYC * 4) @(negedge clock);
    `CHK(irq, 1'b0)
    acc = '0;
    wait_irq(IRQ_RDONE);
    apb(1'b0, OFS_RDATA_LO, 32'h0); `CHK(r, 32'hC0DE_0003)
    // a read on the now empty chain must wait; the wait runs over budget, no read happens
    apb(1'b1, OFS_CTRL, 32'h9);
    acc = '0;
    wait_irq(IRQ_LATE);
    `CHK(acc[IRQ_RDONE], 1'b0)
    stop_test();
  end
  initial begin
    #1_000_000;
    fails++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
